// ---- hdl/fba_arbiter.sv ----
/*
 * fair arbitration node: waits for bus-free, arbitrates with busy and its
 * ID bit, resolves priority, asserts select on a win, and keeps the
 * enabled flag that stops it winning twice before the bus goes idle.
 * assumes open-drain bus lines resolved outside; an output enable low
 * means this node pulls the line low. user logic on core_clk_i raises
 * msg_pending_i and pulses release_i when its selection attempt is done.
 */
`timescale 1ns/100ps
module fba_arbiter (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic [2:0] node_id_i,
	input wire logic msg_pending_i,
	input wire logic release_i,
	input wire logic bus_busy_n_i,
	output logic bus_busy_n_o,
	output logic bus_busy_oe_n_o,
	input wire logic select_line_n_i,
	output logic select_line_n_o,
	output logic select_line_oe_n_o,
	input wire logic [7:0] data_bus_lines_n_i,
	output logic [7:0] data_bus_lines_n_o,
	output logic [7:0] data_bus_lines_oe_n_o,
	input wire logic bus_reset_n_i,
	output logic enabled_o,
	output logic won_o,
	output logic lost_o
);
	import fba_pkg::*;

	// filtered bus view shared with the monitor
	fba_mon_if mon_if ();

	fba_bus_mon u_mon (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.bus_busy_n_i(bus_busy_n_i),
		.select_line_n_i(select_line_n_i),
		.bus_reset_n_i(bus_reset_n_i),
		.data_bus_lines_n_i(data_bus_lines_n_i),
		.mon(mon_if.mon)
	);

	fba_state_e state_reg, state_next;
	fba_cnt_t cnt_reg, cnt_next;
	logic enabled_reg, enabled_next;
	logic busy_oe_n_reg, busy_oe_n_next;
	logic sel_oe_n_reg, sel_oe_n_next;
	logic [7:0] data_oe_n_reg, data_oe_n_next;
	logic won_reg, won_next;
	logic lost_reg, lost_next;
	logic [7:0] id_bit;
	logic [7:0] higher_mask;

	// own line, and every line that outranks it
	assign id_bit = ONE_BIT << node_id_i;
	assign higher_mask = HIGHER_BASE << node_id_i;

	////////////////////////////////////////////////////////////////////
	// arbitration sequence
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		enabled_next = enabled_reg;
		busy_oe_n_next = busy_oe_n_reg;
		sel_oe_n_next = sel_oe_n_reg;
		data_oe_n_next = data_oe_n_reg;
		won_next = won_reg;
		lost_next = 1'b0;

		// idle watch runs in every state, pending message or not
		if (mon_if.idle)
			enabled_next = 1'b1;

		case (state_reg)
		ST_WAIT_FREE: begin
			// nothing driven while waiting
			cnt_next = '0;
			// idle implies bus-free, so a disabled node with a message
			// goes straight to the post-free wait
			if (msg_pending_i && mon_if.bus_free &&
				(enabled_reg || mon_if.idle)) begin
				state_next = ST_POST_FREE;
			end
		end

		// a bus that stops being free sends us back to waiting
		ST_POST_FREE: begin
			if (!mon_if.bus_free) begin
				state_next = ST_WAIT_FREE;
			end else if (cnt_reg >= POST_FREE_CYC - fba_cnt_t'(1)) begin
				// driven on the very next edge, far inside the skew
				// window and the late limit
				if (cnt_reg < LATE_CYC &&
					cnt_reg < POST_FREE_CYC + SKEW_CYC) begin
					busy_oe_n_next = 1'b0;
					data_oe_n_next = ~id_bit;
					state_next = ST_ARB;
					cnt_next = '0;
				end else begin
					state_next = ST_WAIT_FREE;
				end
			end else begin
				cnt_next = cnt_reg + fba_cnt_t'(1);
			end
		end

		// busy and the own line are driven for the whole phase
		ST_ARB: begin
			if (mon_if.sel) begin
				// another node has already selected: drop out now
				busy_oe_n_next = 1'b1;
				data_oe_n_next = ALL_RELEASED;
				lost_next = 1'b1;
				state_next = ST_WAIT_FREE;
			end else if (cnt_reg >= ARB_CYC) begin
				if ((mon_if.data_asserted & higher_mask) != 8'h00) begin
					busy_oe_n_next = 1'b1;
					data_oe_n_next = ALL_RELEASED;
					lost_next = 1'b1;
					state_next = ST_WAIT_FREE;
				end else begin
					sel_oe_n_next = 1'b0;
					enabled_next = 1'b0;
					won_next = 1'b1;
					cnt_next = '0;
					state_next = ST_WIN_HOLD;
				end
			end else begin
				cnt_next = cnt_reg + fba_cnt_t'(1);
			end
		end

		// flag already cleared here, before any line is let go
		ST_WIN_HOLD: begin
			// nothing on the bus changes until the hold expires or a bus reset comes
			if (cnt_reg >= HOLD_CYC - fba_cnt_t'(1))
				state_next = ST_OWNED;
			else
				cnt_next = cnt_reg + fba_cnt_t'(1);
		end

		// release_i is ignored until the hold has run out
		ST_OWNED: begin
			// ownership lasts until the user side lets go or a bus reset comes
			if (release_i) begin
				busy_oe_n_next = 1'b1;
				sel_oe_n_next = 1'b1;
				data_oe_n_next = ALL_RELEASED;
				won_next = 1'b0;
				state_next = ST_WAIT_FREE;
			end
		end

		// unused codes fall back to a released bus
		default: begin
			// keeps the flag, which only idle, a win or reset may change
			state_next = ST_WAIT_FREE;
			busy_oe_n_next = 1'b1;
			sel_oe_n_next = 1'b1;
			data_oe_n_next = ALL_RELEASED;
			won_next = 1'b0;
		end
		endcase

		// bus reset overrides every phase; the flag keeps its value
		// because a bus reset loses no context
		if (mon_if.bus_rst) begin
			busy_oe_n_next = 1'b1;
			sel_oe_n_next = 1'b1;
			data_oe_n_next = ALL_RELEASED;
			won_next = 1'b0;
			cnt_next = '0;
			state_next = ST_WAIT_FREE;
		end
	end

	////////////////////////////////////////////////////////////////////
	// state registers; reset values release every line
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			state_reg <= ST_WAIT_FREE;
			cnt_reg <= '0;
			enabled_reg <= 1'b0;
			busy_oe_n_reg <= 1'b1;
			sel_oe_n_reg <= 1'b1;
			data_oe_n_reg <= ALL_RELEASED;
			won_reg <= 1'b0;
			lost_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			enabled_reg <= enabled_next;
			busy_oe_n_reg <= busy_oe_n_next;
			sel_oe_n_reg <= sel_oe_n_next;
			data_oe_n_reg <= data_oe_n_next;
			won_reg <= won_next;
			lost_reg <= lost_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// open-drain pins: the driven level is always low, enables do the work
	logic pin_low_reg;

	always_ff @(posedge core_clk_i) begin
		pin_low_reg <= 1'b0;
	end

	assign bus_busy_n_o = pin_low_reg;
	assign select_line_n_o = pin_low_reg;
	assign data_bus_lines_n_o = {8{pin_low_reg}};
	assign bus_busy_oe_n_o = busy_oe_n_reg;
	assign select_line_oe_n_o = sel_oe_n_reg;
	assign data_bus_lines_oe_n_o = data_oe_n_reg;

	// status flags for the user side
	assign enabled_o = enabled_reg;
	assign won_o = won_reg;
	assign lost_o = lost_reg;
endmodule

// ---- inc/fba_pkg.sv ----
/*
 * constants for the fair bus arbitration node: timing figures, derived
 * cycle counts, counter and state types.
 * assumes a single 250 MHz device clock and a synchronous active-low reset.
 */
package fba_pkg;

	localparam int CLK_PERIOD_NS = 4;

	localparam int T_FREE_NS = 400;
	localparam int T_POST_FREE_NS = 800;
	localparam int T_SKEW_NS = 600;
	localparam int T_LATE_NS = 1400;
	localparam int T_ARB_NS = 2200;
	localparam int T_HOLD_NS = 1200;
	localparam int T_IDLE_NS = 2200;

	typedef logic [9:0] fba_cnt_t;

	// least times round up, longest times round down
	localparam fba_cnt_t FREE_CYC =
		fba_cnt_t'((T_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam fba_cnt_t POST_FREE_CYC =
		fba_cnt_t'((T_POST_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam fba_cnt_t SKEW_CYC = fba_cnt_t'(T_SKEW_NS / CLK_PERIOD_NS);
	localparam fba_cnt_t LATE_CYC = fba_cnt_t'(T_LATE_NS / CLK_PERIOD_NS);
	localparam fba_cnt_t ARB_CYC =
		fba_cnt_t'((T_ARB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam fba_cnt_t HOLD_CYC =
		fba_cnt_t'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam fba_cnt_t IDLE_CYC =
		fba_cnt_t'((T_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	localparam int DATA_W = 8;
	localparam int SYNC_W = DATA_W + 3;
	localparam int SYNC_BUSY = DATA_W;
	localparam int SYNC_SEL = DATA_W + 1;
	localparam int SYNC_RST = DATA_W + 2;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 11'h7FF;
	localparam logic [DATA_W-1:0] ALL_RELEASED = 8'hFF;
	localparam logic [DATA_W-1:0] HIGHER_BASE = 8'hFE;
	localparam logic [DATA_W-1:0] ONE_BIT = 8'h01;

	typedef enum logic [2:0] {
		ST_WAIT_FREE = 3'b000,
		ST_POST_FREE = 3'b001,
		ST_ARB = 3'b010,
		ST_WIN_HOLD = 3'b011,
		ST_OWNED = 3'b100
	} fba_state_e;

endpackage

// ---- inc/fba_mon_if.sv ----
/*
 * carries the filtered bus levels and the free/idle timing from the bus
 * monitor to the arbitration engine.
 * assumes both ends share the device clock.
 */
`timescale 1ns/100ps
interface fba_mon_if;
	logic busy;
	logic sel;
	logic bus_rst;
	logic [7:0] data_asserted;
	logic bus_free;
	logic idle;

	modport mon (
		output busy,
		output sel,
		output bus_rst,
		output data_asserted,
		output bus_free,
		output idle
	);
	modport arb (
		input busy,
		input sel,
		input bus_rst,
		input data_asserted,
		input bus_free,
		input idle
	);
endinterface

// ---- hdl/fba_bus_mon.sv ----
/*
 * bus monitor: three-stage synchronisers with agreement filter on every
 * incoming bus line, and the continuous free-time counter.
 * assumes bus lines are active low and asynchronous to core_clk_i.
 */
`timescale 1ns/100ps
module fba_bus_mon (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic bus_busy_n_i,
	input wire logic select_line_n_i,
	input wire logic bus_reset_n_i,
	input wire logic [7:0] data_bus_lines_n_i,
	fba_mon_if.mon mon
);
	import fba_pkg::*;

	logic [SYNC_W-1:0] raw;
	logic [SYNC_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
	logic [SYNC_W-1:0] s1_next, s2_next, s3_next, filt_next;
	fba_cnt_t free_cnt_reg, free_cnt_next;
	logic free_now;

	assign raw = {bus_reset_n_i, select_line_n_i, bus_busy_n_i,
		data_bus_lines_n_i};

	////////////////////////////////////////////////////////////////////
	// a level change counts only once stages two and three agree
	genvar i;
	generate
		for (i = 0; i < SYNC_W; i++) begin : g_sync
			always_comb begin
				s1_next[i] = raw[i];
				s2_next[i] = s1_reg[i];
				s3_next[i] = s2_reg[i];
				filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] :
					filt_reg[i];
			end
		end
	endgenerate

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			s1_reg <= SYNC_RESET;
			s2_reg <= SYNC_RESET;
			s3_reg <= SYNC_RESET;
			filt_reg <= SYNC_RESET;
		end else begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			s3_reg <= s3_next;
			filt_reg <= filt_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// counter restarts from zero at reset release, so a bus already
	// free then is timed as if just released
	assign free_now = filt_reg[SYNC_BUSY] & filt_reg[SYNC_SEL] &
		filt_reg[SYNC_RST];

	always_comb begin
		free_cnt_next = free_cnt_reg;
		if (!free_now)
			free_cnt_next = '0;
		else if (free_cnt_reg < IDLE_CYC)
			free_cnt_next = free_cnt_reg + fba_cnt_t'(1);
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i)
			free_cnt_reg <= '0;
		else
			free_cnt_reg <= free_cnt_next;
	end

	assign mon.busy = ~filt_reg[SYNC_BUSY];
	assign mon.sel = ~filt_reg[SYNC_SEL];
	assign mon.bus_rst = ~filt_reg[SYNC_RST];
	assign mon.data_asserted = ~filt_reg[DATA_W-1:0];
	assign mon.bus_free = free_now && (free_cnt_reg >= FREE_CYC);
	// only a few cycles of filter latency, well inside the skew window
	assign mon.idle = free_now && (free_cnt_reg >= IDLE_CYC);
endmodule

// ---- test/fba_checker_assertions.sv ----
/* checker for the arbitration node: timing seen at its ports.
 assumes the bus wire inputs carry resolved levels with pull-ups. */
`timescale 1ns/100ps
module fba_checker (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic [2:0] node_id_i,
	input wire logic bus_busy_n_i,
	input wire logic select_line_n_i,
	input wire logic bus_reset_n_i,
	input wire logic bus_busy_oe_n_o,
	input wire logic select_line_oe_n_o,
	input wire logic [7:0] data_bus_lines_oe_n_o,
	input wire logic enabled_o,
	input wire logic won_o
);
	logic [11:0] free_reg, busy_reg, hold_reg;
	logic free;
	assign free = bus_busy_n_i && select_line_n_i && bus_reset_n_i;
	// saturates so a long quiet bus never wraps back to a small count
	always_ff @(posedge core_clk_i) begin
		free_reg <= (!resetn_i || !free) ? 12'h000
			: free_reg + {11'h000, free_reg != 12'hFFF};
		busy_reg <= bus_busy_oe_n_o ? 12'h000 : busy_reg + 12'h001;
		hold_reg <= select_line_oe_n_o ? 12'h000 : hold_reg + 12'h001;
	end
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);
////////////////////////////////////////////////////////////////////////
	property p_drive;
		$fell(bus_busy_oe_n_o) |-> free_reg >= 300;
	endproperty
	a_drive: assert property (p_drive) else $error("early drive");
	property p_arb;
		$fell(select_line_oe_n_o) |-> busy_reg >= 549 && won_o && !enabled_o;
	endproperty
	a_arb: assert property (p_arb) else $error("bad win");
	property p_hold;
		!select_line_oe_n_o && hold_reg < 298 && bus_reset_n_i |=> $stable(
			{bus_busy_oe_n_o, select_line_oe_n_o, data_bus_lines_oe_n_o});
	endproperty
	a_hold: assert property (p_hold) else $error("hold broken");
	property p_bus_rst;
		$fell(bus_reset_n_i) |-> ##[1:200] bus_busy_oe_n_o
			&& select_line_oe_n_o && data_bus_lines_oe_n_o == 8'hFF;
	endproperty
	a_bus_rst: assert property (p_bus_rst) else $error("no release");
	property p_en_idle;
		$rose(enabled_o) |-> free_reg >= 550;
	endproperty
	a_en_idle: assert property (p_en_idle) else $error("early enable");
	property p_idle_late;
		free_reg == 700 |-> enabled_o;
	endproperty
	a_idle_late: assert property (p_idle_late) else $error("late idle");
	property p_init;
		disable iff (1'b0) !resetn_i |=> !enabled_o && !won_o
			&& bus_busy_oe_n_o && select_line_oe_n_o;
	endproperty
	a_init: assert property (p_init) else $error("bad init");
	property p_one_line;
		data_bus_lines_oe_n_o == 8'hFF
			|| data_bus_lines_oe_n_o == ~(8'h01 << node_id_i);
	endproperty
	a_one_line: assert property (p_one_line) else $error("stray line");
endmodule
bind fba_arbiter fba_checker fba_checker_inst (.*);

// ---- test/fba_peer_model.sv ----
/* peer node: arbitrates beside the node when enabled and the node drives busy.
 assumes the bench resolves wires; a high output pulls that line. */
`timescale 1ns/100ps
module fba_peer_model (
	input wire logic clk_i,
	input wire logic en_i,
	input wire logic [2:0] id_i,
	input wire logic dut_busy_oe_n_i,
	input wire logic sel_n_i,
	input wire logic [7:0] data_n_i,
	output logic busy_o,
	output logic sel_o,
	output logic [7:0] data_o
);
	int t = 0;
	int r = 0;
	initial {busy_o, sel_o, data_o} = '0;
	always @(posedge clk_i) begin
		if (t == 1000 || r == 50) begin
			{busy_o, sel_o, data_o} <= '0;
			t <= 0;
			r <= 0;
		end else if (t == 0 && en_i && !dut_busy_oe_n_i) begin
			busy_o <= 1'b1;
			data_o <= 8'h01 << id_i;
			t <= 1;
		end else if (t != 0) begin
			t <= t + 1;
			if (!sel_n_i && !sel_o)
				r <= r + 1;
			if (t == 600 && (~data_n_i >> id_i) == 8'h01)
				sel_o <= 1'b1;
		end
	end
endmodule

// ---- test/fair_bus_arbitration_test.sv ----
/* bench for the arbitration node against one peer node.
 assumes the peer model, and the checker bound to the node. */
`timescale 1ns/100ps
module fair_bus_arbitration_test;
	typedef struct packed {
		logic [2:0] me;
		logic [2:0] peer;
		logic win;
	} fba_row_s;
	fba_row_s rows [4] = '{'{3'h3, 3'h5, 1'h0}, '{3'h5, 3'h3, 1'h1},
		'{3'h7, 3'h0, 1'h1}, '{3'h0, 3'h7, 1'h0}};
	logic core_clk_i = 1'h0;
	logic resetn_i = 1'h0;
	logic [2:0] node_id_i = 3'h0;
	logic msg_pending_i = 1'h0;
	logic release_i = 1'h0;
	logic bus_reset_n_i = 1'h1;
	logic pen = 1'h0;
	logic [2:0] pid = 3'h0;
	logic bus_busy_n_o, bus_busy_oe_n_o, select_line_n_o, select_line_oe_n_o;
	logic [7:0] data_bus_lines_n_o, data_bus_lines_oe_n_o, pd;
	logic enabled_o, won_o, lost_o, pb, ps;
	wire bus_busy_n_i = bus_busy_oe_n_o & ~pb;
	wire select_line_n_i = select_line_oe_n_o & ~ps;
	wire [7:0] data_bus_lines_n_i = data_bus_lines_oe_n_o & ~pd;
	int n_mismatch = 0;
	int n_tests = 0;
	int cyc = 0;
	fba_arbiter fba_arbiter_inst (.*);
	fba_peer_model fba_peer_model_inst (.clk_i(core_clk_i), .en_i(pen),
		.id_i(pid), .dut_busy_oe_n_i(bus_busy_oe_n_o),
		.sel_n_i(select_line_n_i), .data_n_i(data_bus_lines_n_i),
		.busy_o(pb), .sel_o(ps), .data_o(pd));
////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'h1) begin
			n_mismatch++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask
	task automatic wait_out(input int lim);
		for (int i = 0; i < lim && won_o !== 1'h1 && lost_o !== 1'h1; i++)
			wt(1);
	endtask
	task automatic own(input logic [2:0] id);
		chk(enabled_o === 1'h0 && bus_busy_oe_n_o === 1'h0, "flag");
		chk(data_bus_lines_oe_n_o === ~(8'h01 << id), "id line");
		chk(bus_busy_n_o === 1'h0 && select_line_n_o === 1'h0
			&& data_bus_lines_n_o === 8'h00, "pin level");
		wt(310);
		release_i = 1'h1;
		wt(1);
		release_i = 1'h0;
		wt(1);
		chk(select_line_oe_n_o === 1'h1 && won_o === 1'h0, "release");
	endtask
	task automatic conclude;
		$display("checks %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
////////////////////////////////////////////////////////////////////////
	initial begin
		forever #2 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			chk(1'h0, "timeout");
			conclude();
		end
	end
	initial begin
		wt(2);
		chk(enabled_o === 1'h0 && won_o === 1'h0, "reset");
		foreach (rows[k]) begin
			resetn_i = 1'h0;
			node_id_i = rows[k].me;
			pid = rows[k].peer;
			msg_pending_i = 1'h0;
			wt(2);
			resetn_i = 1'h1;
			pen = 1'h1;
			wt(1);
			msg_pending_i = 1'h1;
			wait_out(2000);
			pen = 1'h0;
			chk(won_o === rows[k].win, "outcome");
			chk(lost_o === !rows[k].win, "lost flag");
			if (!rows[k].win) begin
				wt(1);
				wait_out(3000);
				chk(won_o === 1'h1, "retry");
			end
			own(rows[k].me);
		end
		wt(400);
		chk(bus_busy_oe_n_o === 1'h1, "disabled");
		wait_out(1500);
		chk(won_o === 1'h1, "idle then win");
		own(node_id_i);
		for (int i = 0; i < 1500 && bus_busy_oe_n_o !== 1'h0; i++)
			wt(1);
		bus_reset_n_i = 1'h0;
		wt(201);
		chk(data_bus_lines_oe_n_o === 8'hFF, "bus reset");
		bus_reset_n_i = 1'h1;
		msg_pending_i = 1'h0;
		resetn_i = 1'h0;
		wt(2);
		resetn_i = 1'h1;
		wt(540);
		chk(enabled_o === 1'h0, "idle early");
		wt(160);
		chk(enabled_o === 1'h1, "idle late");
		conclude();
	end
endmodule
